/* File: hdl/abf_buf.sv */
// two-entry buffer with registered outputs
`timescale 1ns/100ps
module abf_buf #(
  parameter int W = 8
) (
  // clocking
  input  wire logic         clock,
  input  wire logic         rstN,
  input  wire logic         ce,
  // fill side
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  // drain side
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  logic         headV_q, headV_d, spareV_q, spareV_d;
  logic [W-1:0] head_q, head_d, spare_q, spare_d;

  always_comb begin
    logic headFree;
    logic push;
    headFree = !headV_q || outReady;
    push     = inValid && !spareV_q;
    headV_d  = headV_q;
    head_d   = head_q;
    spareV_d = spareV_q;
    spare_d  = spare_q;
    if (headFree) begin
      if (spareV_q) begin
        head_d   = spare_q;
        headV_d  = 1'b1;
        spareV_d = 1'b0;
      end else begin
        head_d  = inData;
        headV_d = push;
      end
    end else if (push) begin
      spare_d  = inData;
      spareV_d = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      headV_q  <= 1'b0;
      spareV_q <= 1'b0;
      head_q   <= '0;
      spare_q  <= '0;
    end else if (ce) begin
      headV_q  <= headV_d;
      spareV_q <= spareV_d;
      head_q   <= head_d;
      spare_q  <= spare_d;
    end
  end

  assign inReady  = !spareV_q;
  assign outValid = headV_q;
  assign outData  = head_q;
endmodule

/* File: hdl/abf_framer.sv */
// adapter-side frame builder and response parser
`timescale 1ns/100ps
`include "abf_cfg.svh"
// Contract
// - object access response: STX 02, type 0003, command 94, echoed function, length 8+n.
// - response result codes accept, accept-net-down, reject, four mismatches, other error.
// - object info: 3-byte object, 2-byte length, property, data up to 245 bytes.
// - length 01 means alteration response, anything else a reference response.
// - bulk request: STX 02, type 0003, command 20, any function, length sums data.
// - operation byte: 00/01 cached-get read/notify, 02/03 cached-set read/notify.
// - object code follows operation; value list only for notify operations.
// - notify list holds own values, descending codes, maps and identity omitted.
// - pass-through request reads get values or forwards set values for other nodes.
// - command-error reply to pass-through makes adapter fall back to single requests.
// - pass-through request: command 21, operation 00 read, 01 write.
module abf_framer
  import abf_pkg::*;
(
  // clocking
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         ce,
  // frame requests
  input  wire logic         reqValid,
  input  wire abf_req_type  req,
  output logic              reqReady,
  // payload bytes after the fixed fields
  input  wire logic         payValid,
  input  wire logic [7:0]   payByte,
  output logic              payReady,
  // serial bytes toward the appliance
  output logic              txValid,
  output logic [7:0]        txByte,
  input  wire logic         txReady,
  // serial bytes from the appliance
  input  wire logic         rxValid,
  input  wire logic [7:0]   rxByte,
  // parsed answers
  output logic              respValid,
  output abf_resp_type      resp,
  output logic              respBad,
  output logic              fallback
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rstA_q, rstN;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstA_q <= 1'b0;
      rstN   <= 1'b0;
    end else begin
      rstA_q <= 1'b1;
      rstN   <= rstA_q;
    end
  end

  function automatic logic [15:0] resCode(input abf_res_type r);
    case (r)
      RES_ACCEPT:  resCode = `ABF_RES_ACCEPT;
      RES_ACC_NET: resCode = `ABF_RES_ACC_NET;
      RES_REJECT:  resCode = `ABF_RES_REJECT;
      RES_UNCONF:  resCode = `ABF_RES_UNCONF;
      RES_STANDBY: resCode = `ABF_RES_STANDBY;
      RES_BUILD:   resCode = `ABF_RES_BUILD;
      RES_ERRSTOP: resCode = `ABF_RES_ERRSTOP;
      default:     resCode = `ABF_RES_OTHER;
    endcase
  endfunction

  // ----------------------------------------
  // transmit frame builder
  // ----------------------------------------
  typedef enum logic [3:0] {
    T_IDLE = 4'h1, T_HDR = 4'h2, T_PAY = 4'h4, T_SUM = 4'h8
  } abf_tst_type;

  abf_tst_type tst_q, tst_d;
  abf_req_type rq_q, rq_d;
  abf_hdr_type hdr_q, hdr_d;
  logic [3:0]  hLeft_q, hLeft_d;
  logic [15:0] pLeft_q, pLeft_d, frmLen_q, frmLen_d;
  logic [7:0]  sum_q, sum_d, pushByte;
  logic        pushValid, bufReady, passOut_set;

  always_comb begin
    logic [15:0] n;
    logic [15:0] frmLen;
    logic [7:0]  cmdByte;
    n           = req.n;
    frmLen      = '0;
    cmdByte     = `ABF_CMD_SINGLEREQ;
    tst_d       = tst_q;
    rq_d        = rq_q;
    hdr_d       = hdr_q;
    hLeft_d     = hLeft_q;
    pLeft_d     = pLeft_q;
    frmLen_d    = frmLen_q;
    sum_d       = sum_q;
    pushValid   = 1'b0;
    pushByte    = hdr_q[14];
    passOut_set = 1'b0;
    case (tst_q)
      T_IDLE: begin
        if (reqValid) begin
          case (req.kind)
            KIND_OBJRESP: begin
              if (n > `ABF_MAX_DATA) n = `ABF_MAX_DATA;
              frmLen  = `ABF_FIX_OBJRESP + n;
              cmdByte = `ABF_CMD_OBJRESP;
              hLeft_d = `ABF_HLEN_OBJ;
              hdr_d   = {`ABF_STX, `ABF_FRAME_TYPE, cmdByte, req.funcNum, frmLen,
                         resCode(req.res), req.obj,
                         16'(`ABF_PROP_LEN + n), req.prop};
            end
            KIND_BULK, KIND_PASS: begin
              if (req.kind == KIND_BULK) begin
                cmdByte = `ABF_CMD_BULKREQ;
                if (!req.op[0]) n = '0;
              end else begin
                cmdByte = `ABF_CMD_PASSREQ;
                passOut_set = 1'b1;
              end
              frmLen  = `ABF_FIX_BULK + n;
              hLeft_d = `ABF_HLEN_CMD;
              hdr_d   = abf_hdr_type'({`ABF_STX, `ABF_FRAME_TYPE, cmdByte, req.funcNum, frmLen,
                         8'(req.op), req.obj})
                        << (8 * (`ABF_HLEN_OBJ - `ABF_HLEN_CMD));
            end
            default: begin
              frmLen  = `ABF_FIX_SINGLE + n;
              hLeft_d = `ABF_HLEN_SGL;
              hdr_d   = abf_hdr_type'({`ABF_STX, `ABF_FRAME_TYPE, cmdByte, req.funcNum, frmLen,
                         req.obj})
                        << (8 * (`ABF_HLEN_OBJ - `ABF_HLEN_SGL));
            end
          endcase
          rq_d    = req;
          rq_d.n  = n;
          pLeft_d = n;
          frmLen_d = frmLen;
          sum_d   = `ABF_STX; // cancels the start byte
          tst_d   = T_HDR;
        end
      end
      T_HDR: begin
        pushValid = 1'b1;
        if (bufReady) begin
          sum_d   = sum_q ^ hdr_q[14];
          hdr_d   = hdr_q << 8;
          hLeft_d = hLeft_q - 4'h1;
          if (hLeft_q == 4'h1) tst_d = (pLeft_q == '0) ? T_SUM : T_PAY;
        end
      end
      T_PAY: begin
        pushValid = payValid;
        pushByte  = payByte;
        if (payValid && bufReady) begin
          sum_d   = sum_q ^ payByte;
          pLeft_d = pLeft_q - 16'h0001;
          if (pLeft_q == 16'h0001) tst_d = T_SUM;
        end
      end
      T_SUM: begin
        pushValid = 1'b1;
        pushByte  = sum_q;
        if (bufReady) tst_d = T_IDLE;
      end
      default: tst_d = T_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      tst_q   <= T_IDLE;
      rq_q    <= '0;
      hdr_q   <= '0;
      hLeft_q <= '0;
      pLeft_q <= '0;
      frmLen_q <= '0;
      sum_q   <= '0;
    end else if (ce) begin
      tst_q   <= tst_d;
      rq_q    <= rq_d;
      hdr_q   <= hdr_d;
      hLeft_q <= hLeft_d;
      pLeft_q <= pLeft_d;
      frmLen_q <= frmLen_d;
      sum_q   <= sum_d;
    end
  end

  assign reqReady = tst_q[0];
  assign payReady = (tst_q == T_PAY) && bufReady;

  abf_buf #(.W(8)) u_abf_buf (
    .clock    (clock),
    .rstN     (rstN),
    .ce       (ce),
    .inValid  (pushValid),
    .inData   (pushByte),
    .inReady  (bufReady),
    .outValid (txValid),
    .outData  (txByte),
    .outReady (txReady)
  );

  // ----------------------------------------
  // receive parser
  // ----------------------------------------
  typedef enum logic [3:0] {
    R_IDLE = 4'h1, R_HDR = 4'h2, R_DATA = 4'h4, R_SUM = 4'h8
  } abf_rst_type;

  abf_rst_type  rst_q, rst_d;
  logic [47:0]  rHdr_q, rHdr_d;
  logic [15:0]  rRes_q, rRes_d, rCnt_q, rCnt_d;
  logic [7:0]   rSum_q, rSum_d;
  logic         respV_q, respV_d, bad_q, bad_d, fb_q, fb_d;
  logic         passOut_q, passOut_d;
  abf_resp_type resp_q, resp_d;

  always_comb begin
    logic good;
    good      = 1'b0;
    rst_d     = rst_q;
    rHdr_d    = rHdr_q;
    rRes_d    = rRes_q;
    rCnt_d    = rCnt_q;
    rSum_d    = rSum_q;
    resp_d    = resp_q;
    respV_d   = 1'b0;
    bad_d     = 1'b0;
    fb_d      = 1'b0;
    passOut_d = passOut_q;
    if (rxValid) begin
      case (rst_q)
        R_IDLE: begin
          if (rxByte == `ABF_STX) begin
            rst_d  = R_HDR;
            rSum_d = '0;
            rCnt_d = 16'(`ABF_RXHDR_LEN);
            rRes_d = `ABF_RES_OTHER;
          end
        end
        R_HDR: begin
          rHdr_d = {rHdr_q[39:0], rxByte};
          rSum_d = rSum_q ^ rxByte;
          rCnt_d = rCnt_q - 16'h0001;
          if (rCnt_q == 16'h0001) begin
            if (rHdr_q[39:24] != `ABF_FRAME_TYPE) rst_d = R_IDLE;
            else begin
              rCnt_d = {rHdr_q[7:0], rxByte};
              rst_d  = ({rHdr_q[7:0], rxByte} == '0) ? R_SUM : R_DATA;
            end
          end
        end
        R_DATA: begin
          if (rCnt_q + 16'h0002 > rHdr_q[15:0] + 16'h0000 &&
              rHdr_q[15:0] - rCnt_q < 16'h0002)
            rRes_d = {rRes_q[7:0], rxByte};
          rSum_d = rSum_q ^ rxByte;
          rCnt_d = rCnt_q - 16'h0001;
          if (rCnt_q == 16'h0001) rst_d = R_SUM;
        end
        R_SUM: begin
          good    = (rxByte == rSum_q);
          respV_d = good;
          bad_d   = !good;
          resp_d  = '{cmd: rHdr_q[31:24], funcNum: rHdr_q[23:16],
                      result: rRes_q, dataLen: rHdr_q[15:0]};
          rst_d   = R_IDLE;
        end
        default: rst_d = R_IDLE;
      endcase
    end
    if (good && passOut_q) begin
      if (rHdr_q[31:24] == `ABF_CMD_PASSRSP) passOut_d = 1'b0;
      if (rHdr_q[31:24] == `ABF_CMD_COMMERR) begin
        passOut_d = 1'b0;
        fb_d      = (rRes_q == `ABF_ERR_CMD);
      end
    end
    if (passOut_set && ce) passOut_d = 1'b1; // set wins
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      rst_q     <= R_IDLE;
      rHdr_q    <= '0;
      rRes_q    <= '0;
      rCnt_q    <= '0;
      rSum_q    <= '0;
      resp_q    <= '0;
      respV_q   <= 1'b0;
      bad_q     <= 1'b0;
      fb_q      <= 1'b0;
      passOut_q <= 1'b0;
    end else if (ce) begin
      rst_q     <= rst_d;
      rHdr_q    <= rHdr_d;
      rRes_q    <= rRes_d;
      rCnt_q    <= rCnt_d;
      rSum_q    <= rSum_d;
      resp_q    <= resp_d;
      respV_q   <= respV_d;
      bad_q     <= bad_d;
      fb_q      <= fb_d;
      passOut_q <= passOut_d;
    end
  end

  assign respValid = respV_q;
  assign resp      = resp_q;
  assign respBad   = bad_q;
  assign fallback  = fb_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);

  sequence hdrAt(logic [3:0] left);
    tst_q == T_HDR && bufReady && ce && hLeft_q == left;
  endsequence
  sequence cmdSlot(abf_kind_type k, logic [3:0] len);
    hdrAt(len - `ABF_POS_CMD) ##0 rq_q.kind == k;
  endsequence

  a_stx_lead: assert property (tst_q == T_IDLE && reqValid && ce |=> pushByte == `ABF_STX)
    else $error("frame does not open with start byte");
  a_objresp_cmd: assert property (cmdSlot(KIND_OBJRESP, `ABF_HLEN_OBJ) |-> pushByte == `ABF_CMD_OBJRESP)
    else $error("object response command wrong");
  a_bulk_cmd: assert property (cmdSlot(KIND_BULK, `ABF_HLEN_CMD) |-> pushByte == `ABF_CMD_BULKREQ)
    else $error("bulk request command wrong");
  a_pass_cmd: assert property (cmdSlot(KIND_PASS, `ABF_HLEN_CMD) |-> pushByte == `ABF_CMD_PASSREQ)
    else $error("pass-through command wrong");
  a_objresp_len: assert property (tst_q == T_HDR && rq_q.kind == KIND_OBJRESP
      |-> frmLen_q == `ABF_FIX_OBJRESP + rq_q.n && rq_q.n <= `ABF_MAX_DATA)
    else $error("object response length wrong");
  a_read_nolist: assert property (tst_q == T_HDR && rq_q.kind == KIND_BULK && !rq_q.op[0]
      |-> frmLen_q == `ABF_FIX_BULK)
    else $error("read request carries a list");
  a_sum_tail: assert property (tst_q == T_SUM && bufReady && ce
      |-> pushByte == sum_q ##1 tst_q == T_IDLE)
    else $error("checksum byte or frame end wrong");
  a_fallback_go: assert property (rst_q == R_SUM && rxValid && ce && rxByte == rSum_q && passOut_q && !passOut_set
      && rHdr_q[31:24] == `ABF_CMD_COMMERR && rRes_q == `ABF_ERR_CMD |=> fallback && !passOut_q)
    else $error("fallback not raised");
  a_bad_drop: assert property (respBad |-> !respValid)
    else $error("bad frame reported as answer");
endmodule

/* File: shared/abf_cfg.svh */
// frame constants for the adapter bulk access framer
`ifndef ABF_CFG_SVH
`define ABF_CFG_SVH
`define ABF_STX           8'h02
`define ABF_FRAME_TYPE    16'h0003
`define ABF_CMD_OBJRESP   8'h94
`define ABF_CMD_BULKREQ   8'h20
`define ABF_CMD_BULKRSP   8'hA0
`define ABF_CMD_PASSREQ   8'h21
`define ABF_CMD_PASSRSP   8'hA1
`define ABF_CMD_SINGLEREQ 8'h10
`define ABF_CMD_COMMERR   8'hFF
`define ABF_ERR_CMD       16'h0001
`define ABF_RES_ACCEPT    16'h0000
`define ABF_RES_ACC_NET   16'h0001
`define ABF_RES_REJECT    16'h0011
`define ABF_RES_UNCONF    16'h0101
`define ABF_RES_STANDBY   16'h0103
`define ABF_RES_BUILD     16'h0104
`define ABF_RES_ERRSTOP   16'h0105
`define ABF_RES_OTHER     16'hFFFF
`define ABF_FIX_OBJRESP   16'h0008
`define ABF_FIX_BULK      16'h0004
`define ABF_FIX_SINGLE    16'h0003
`define ABF_PROP_LEN      16'h0001
`define ABF_MAX_DATA      16'h00F5
`define ABF_HLEN_OBJ      4'hF
`define ABF_HLEN_CMD      4'hB
`define ABF_HLEN_SGL      4'hA
`define ABF_POS_CMD       4'h3
`define ABF_RXHDR_LEN     4'h6
`endif

/* File: shared/abf_pkg.sv */
// types for the adapter bulk access framer
package abf_pkg;
  typedef enum logic [1:0] {
    KIND_OBJRESP = 2'h0,
    KIND_BULK    = 2'h1,
    KIND_PASS    = 2'h2,
    KIND_SINGLE  = 2'h3
  } abf_kind_type;
  typedef enum logic [2:0] {
    RES_ACCEPT, RES_ACC_NET, RES_REJECT, RES_UNCONF,
    RES_STANDBY, RES_BUILD, RES_ERRSTOP, RES_OTHER
  } abf_res_type;
  typedef struct packed {
    abf_kind_type kind;
    logic [7:0]   funcNum;
    logic [1:0]   op;
    abf_res_type  res;
    logic [23:0]  obj;
    logic [7:0]   prop;
    logic [15:0]  n;
  } abf_req_type;
  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  funcNum;
    logic [15:0] result;
    logic [15:0] dataLen;
  } abf_resp_type;
  typedef logic [14:0][7:0] abf_hdr_type;
endpackage

/* File: tb/abf_appliance.sv */
// behavioural appliance controller facing the framer's serial side
`timescale 1ns/100ps
module abf_appliance (
  // clocking
  input  wire logic       clock,
  input  wire logic       nrst,
  // bytes from the framer
  input  wire logic       txValid,
  input  wire logic [7:0] txByte,
  output logic            txReady,
  // bytes toward the framer
  output logic            rxValid,
  output logic [7:0]      rxByte,
  // behaviour controls
  input  wire logic       slow,
  input  wire logic       rejectPass,
  input  wire logic       badSum
);
  logic [7:0] got[$];
  logic [7:0] cur[$];
  logic [7:0] out[$];
  logic [7:0] cyc;

  // ----------------------------------------
  // answer building
  // ----------------------------------------
  task automatic reply();
    logic [7:0] r[$];
    logic [7:0] cs;
    if (cur[3] == 8'h20) begin
      r = {8'hA0, cur[4], 8'h00, 8'h00};
      if ({cur[8], cur[9], cur[10]} == 24'h000000) r[3] = 8'h11;
      else if (cur[7] == 8'h00 || cur[7] == 8'h02) r = {r, 8'hF0, 8'h31, 8'h80, 8'h30};
    end else if (cur[3] == 8'h21 && rejectPass) begin
      r = {8'hFF, cur[4], 8'h00, 8'h01};
    end else if (cur[3] == 8'h21) begin
      r = {8'hA1, cur[4], 8'h00, 8'h00};
    end else begin
      return;
    end
    r = {8'h00, 8'h03, r[0], r[1], 8'h00, 8'(r.size() - 2), r[2:$]};
    cs = 8'h00;
    foreach (r[i]) cs ^= r[i];
    out = {out, 8'h02, r, cs ^ (badSum ? 8'hFF : 8'h00)};
  endtask

  // stall half of the time when slow, idle rx line toggles
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txReady <= 1'b0;
      rxValid <= 1'b0;
      rxByte  <= 8'hFF;
      cyc     <= 8'h00;
      cur.delete();
      out.delete();
    end else begin
      cyc     <= cyc + 8'h01;
      txReady <= slow ? cyc[2] : 1'b1;
      if (txValid && txReady) begin
        got.push_back(txByte);
        cur.push_back(txByte);
      end
      if (cur.size() >= 7 && cur.size() == 8 + {cur[5], cur[6]}) begin
        reply();
        cur.delete();
      end
      if (out.size() > 0) begin
        rxValid <= 1'b1;
        rxByte  <= out.pop_front();
      end else begin
        rxValid <= 1'b0;
        rxByte  <= ~rxByte;
      end
    end
  end
endmodule

/* File: tb/test_adapter_bulk_access_framer.sv */
// self-checking bench for the adapter bulk access framer
`timescale 1ns/100ps
module test_adapter_bulk_access_framer import abf_pkg::*;;
  typedef logic [7:0] abf_bytes_type[$];
  logic         clock = 1'b0, nrst = 1'b0, reqValid = 1'b0, payValid = 1'b0;
  logic         slow = 1'b0, rejectPass = 1'b0, badSum = 1'b0;
  abf_req_type  req = '0;
  logic [7:0]   payByte = 8'h00;
  logic         reqReady, payReady, txValid, txReady, rxValid, respValid, respBad, fallback;
  logic [7:0]   txByte, rxByte;
  abf_resp_type resp;
  int           err_count = 0, tests_run = 0, rdPtr = 0;

  always #5 clock = ~clock;

  abf_framer u_abf_framer (.clock(clock), .nrst(nrst), .ce(1'b1), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .payValid(payValid), .payByte(payByte), .payReady(payReady),
    .txValid(txValid), .txByte(txByte), .txReady(txReady), .rxValid(rxValid), .rxByte(rxByte),
    .respValid(respValid), .resp(resp), .respBad(respBad), .fallback(fallback));
  abf_appliance u_abf_appliance (.clock(clock), .nrst(nrst), .txValid(txValid), .txByte(txByte),
    .txReady(txReady), .rxValid(rxValid), .rxByte(rxByte), .slow(slow), .rejectPass(rejectPass),
    .badSum(badSum));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(logic [63:0] seen, logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic sendReq(abf_kind_type k, logic [7:0] f, logic [1:0] o, abf_res_type rs,
                         logic [23:0] ob, logic [15:0] n);
    int w;
    int m;
    // payload actually pulled: clamped object data, none for bulk reads
    m = (k == KIND_OBJRESP && n > 16'd245) ? 245 : int'(n);
    if (k == KIND_BULK && !o[0]) m = 0;
    req      <= '{k, f, o, rs, ob, 8'h80, n};
    reqValid <= 1'b1;
    w = 0;
    do @(posedge clock); while (reqReady !== 1'b1 && ++w < 500);
    if (w >= 500) err_count++;
    reqValid <= 1'b0;
    for (int i = 0; i < m; i++) begin
      payValid <= 1'b1;
      payByte  <= 8'h40 + 8'(i);
      w = 0;
      do @(posedge clock); while (payReady !== 1'b1 && ++w < 500);
      if (w >= 500) err_count++;
    end
    payValid <= 1'b0;
  endtask

  task automatic checkFrame(logic [7:0] cmd, logic [7:0] f, abf_bytes_type body);
    abf_bytes_type e;
    logic [7:0]    cs;
    int            w;
    e = {8'h02, 8'h00, 8'h03, cmd, f, 8'h00, 8'(body.size()), body};
    cs = 8'h00;
    for (int i = 1; i < e.size(); i++) cs ^= e[i];
    e.push_back(cs);
    w = 0;
    while (u_abf_appliance.got.size() < rdPtr + e.size() && w++ < 3000) @(posedge clock);
    foreach (e[i]) check(u_abf_appliance.got[rdPtr + i], e[i]);
    rdPtr += e.size();
  endtask

  task automatic waitResp(logic bad, logic fb, logic [7:0] cmd, logic [7:0] f, logic [15:0] res,
                          logic [15:0] len);
    int w;
    w = 0;
    while (respValid !== 1'b1 && respBad !== 1'b1 && w++ < 300) @(posedge clock);
    if (w > 300) err_count++;
    check(respBad, bad);
    check(fallback, fb);
    if (!bad) check(resp, {cmd, f, res, len});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic objRespAll();
    logic [15:0] c[8];
    c = '{16'h0000, 16'h0001, 16'h0011, 16'h0101, 16'h0103, 16'h0104, 16'h0105, 16'hFFFF};
    for (int i = 0; i < 8; i++) begin
      sendReq(KIND_OBJRESP, 8'(i), 2'h0, abf_res_type'(i), 24'h0130A1, 16'h0000);
      checkFrame(8'h94, 8'(i), {c[i][15:8], c[i][7:0], 8'h01, 8'h30, 8'hA1, 8'h00, 8'h01, 8'h80});
    end
    sendReq(KIND_OBJRESP, 8'hC3, 2'h0, RES_ACCEPT, 24'h0130A1, 16'h0003);
    checkFrame(8'h94, 8'hC3, {8'h00, 8'h00, 8'h01, 8'h30, 8'hA1, 8'h00, 8'h04, 8'h80,
                             8'h40, 8'h41, 8'h42});
  endtask

  task automatic objClamp();
    abf_bytes_type b;
    b = {8'h00, 8'h00, 8'h01, 8'h30, 8'hA1, 8'h00, 8'hF6, 8'h80};
    for (int i = 0; i < 245; i++) b.push_back(8'h40 + 8'(i));
    slow <= 1'b1;
    sendReq(KIND_OBJRESP, 8'h3C, 2'h0, RES_ACCEPT, 24'h0130A1, 16'h00F6);
    checkFrame(8'h94, 8'h3C, b);
    slow <= 1'b0;
  endtask

  task automatic bulkAll();
    abf_bytes_type b;
    logic [7:0]    f;
    for (int op = 0; op < 4; op++) begin
      f = (op == 3) ? 8'hFF : 8'(op);
      b = {8'(op), 8'h01, 8'h30, 8'hA1};
      if (op % 2 == 1) b = {b, 8'h40, 8'h41};
      sendReq(KIND_BULK, f, 2'(op), RES_ACCEPT, 24'h0130A1, (op % 2 == 1) ? 16'h0002 : 16'h0000);
      checkFrame(8'h20, f, b);
      waitResp(1'b0, 1'b0, 8'hA0, f, 16'h0000, (op % 2 == 1) ? 16'h0002 : 16'h0006);
    end
    sendReq(KIND_BULK, 8'h55, 2'h0, RES_ACCEPT, 24'h000000, 16'h0000);
    checkFrame(8'h20, 8'h55, {8'h00, 8'h00, 8'h00, 8'h00});
    waitResp(1'b0, 1'b0, 8'hA0, 8'h55, 16'h0011, 16'h0002);
  endtask

  task automatic passAndFallback();
    sendReq(KIND_PASS, 8'h61, 2'h0, RES_ACCEPT, 24'h0130A1, 16'h0000);
    checkFrame(8'h21, 8'h61, {8'h00, 8'h01, 8'h30, 8'hA1});
    waitResp(1'b0, 1'b0, 8'hA1, 8'h61, 16'h0000, 16'h0002);
    rejectPass <= 1'b1;
    sendReq(KIND_PASS, 8'h62, 2'h1, RES_ACCEPT, 24'h0130A1, 16'h0002);
    checkFrame(8'h21, 8'h62, {8'h01, 8'h01, 8'h30, 8'hA1, 8'h40, 8'h41});
    waitResp(1'b0, 1'b1, 8'hFF, 8'h62, 16'h0001, 16'h0002);
    rejectPass <= 1'b0;
    sendReq(KIND_SINGLE, 8'h62, 2'h0, RES_ACCEPT, 24'h0130A1, 16'h0002);
    checkFrame(8'h10, 8'h62, {8'h01, 8'h30, 8'hA1, 8'h40, 8'h41});
  endtask

  task automatic badChecksum();
    badSum <= 1'b1;
    sendReq(KIND_BULK, 8'h77, 2'h1, RES_ACCEPT, 24'h0130A1, 16'h0000);
    checkFrame(8'h20, 8'h77, {8'h01, 8'h01, 8'h30, 8'hA1});
    waitResp(1'b1, 1'b0, 8'h00, 8'h00, 16'h0000, 16'h0000);
    badSum <= 1'b0;
  endtask

  initial begin
    repeat (3) @(posedge clock);
    // ready is the idle state bit, so it already stands during reset
    check({reqReady, txValid, respValid, respBad, fallback}, 5'h10);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    check(reqReady, 1'b1);
    objRespAll();
    objClamp();
    bulkAll();
    passAndFallback();
    badChecksum();
    repeat (20) @(posedge clock);
    tally_and_finish();
  end

  // hang guard, well beyond the expected run
  initial begin
    #300us;
    err_count++;
    tally_and_finish();
  end
endmodule
